// File: pecs_pkg.sv
// pecs_pkg: constants shared by the phy error counter and extended status block
// assumes: apb byte addresses are four times the register index
package pecs_pkg;

  // ------------------------------------------------------------
  // register indexes (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_RX_ERR_CNT  = 8'h13;
  localparam logic [7:0] IDX_FALSE_CAR   = 8'h14;
  localparam logic [7:0] IDX_UNSTABLE    = 8'h15;
  localparam logic [7:0] IDX_TEN_CS      = 8'h16;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLEAR   = 8'h21;
  localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h22;

  // ------------------------------------------------------------
  // counter layout
  // ------------------------------------------------------------
  localparam int         CNT_W   = 8;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_RST = 8'h00;

  // ------------------------------------------------------------
  // ten_meg_control_status fields
  // ------------------------------------------------------------
  localparam int CS_FORCE_LINK = 15;
  localparam int CS_JABBER_OFF = 14;
  localparam int CS_ECHO_OFF   = 13;
  localparam int CS_HB_OFF     = 12;
  localparam int CS_SQ_HI      = 11;
  localparam int CS_SQ_LO      = 10;
  localparam int CS_EOF_ERR    = 8;
  localparam int CS_DISCONNECT = 7;
  localparam int CS_LINK       = 6;

  localparam logic CS_FORCE_LINK_RST = 1'b0;
  localparam logic CS_JABBER_OFF_RST = 1'b0;
  localparam logic CS_ECHO_OFF_RST   = 1'b1;
  localparam logic CS_HB_OFF_RST     = 1'b1;

  typedef enum logic [1:0] {
    SQ_NORMAL   = 2'b00,
    SQ_LOW      = 2'b01,
    SQ_HIGH     = 2'b10,
    SQ_RESERVED = 2'b11
  } pecs_squelch_t;

  // ------------------------------------------------------------
  // interrupt bits
  // ------------------------------------------------------------
  localparam int IRQ_W       = 5;
  localparam int IRQ_RX_ERR  = 0;
  localparam int IRQ_FALSE   = 1;
  localparam int IRQ_UNSTAB  = 2;
  localparam int IRQ_EOF     = 3;
  localparam int IRQ_DISC    = 4;
  localparam logic [4:0] IRQ_RST = 5'h00;

  function automatic logic [15:0] byte_addr(input logic [7:0] idx);
    byte_addr = {6'h00, idx, 2'b00};
  endfunction

endpackage

// File: pecs_cnt_if.sv
// pecs_cnt_if: event, clear and value of one saturating event counter
// assumes: all signals on core_clk_i
`timescale 1ns/1ps
interface pecs_cnt_if;
  logic                     inc;     // one event this cycle
  logic                     rd_clr;  // cleared by a register read
  logic                     rst_clr; // cleared by software reset
  logic [pecs_pkg::CNT_W-1:0] cnt;

  modport ctl (output inc, output rd_clr, output rst_clr, input cnt);
  modport ctr (input inc, input rd_clr, input rst_clr, output cnt);
endinterface

// File: pecs_sat_cnt.sv
// pecs_sat_cnt: eight-bit saturating event counter with read and reset clear
// assumes: inc is a one-cycle pulse from logic on core_clk_i
`timescale 1ns/1ps
module pecs_sat_cnt (
  input wire logic core_clk_i, // core clock
  input wire logic nrst_i,     // async hardware reset, active low
  pecs_cnt_if.ctr  c           // counter controls and value
);

  logic [pecs_pkg::CNT_W-1:0] cnt_q;
  logic [pecs_pkg::CNT_W-1:0] cnt_d;

  // a read clear loses to a same-cycle event so that event is not dropped
  always_comb begin
    cnt_d = cnt_q;
    if (c.rst_clr) begin
      cnt_d = pecs_pkg::CNT_RST;
    end else if (c.rd_clr) begin
      cnt_d = c.inc ? pecs_pkg::CNT_W'(1) : pecs_pkg::CNT_RST;
    end else if (c.inc && cnt_q != pecs_pkg::CNT_MAX) begin
      cnt_d = cnt_q + pecs_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= pecs_pkg::CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign c.cnt = cnt_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_cnt_step;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (c.inc && !c.rd_clr && !c.rst_clr && cnt_q != pecs_pkg::CNT_MAX) |=>
      (cnt_q == $past(cnt_q) + pecs_pkg::CNT_W'(1));
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step on event");

  property p_cnt_sat;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (cnt_q == pecs_pkg::CNT_MAX && !c.rd_clr && !c.rst_clr) |=> (cnt_q == pecs_pkg::CNT_MAX);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped past maximum");

  property p_cnt_rd_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (c.rd_clr && !c.rst_clr) |=> (cnt_q == (($past(c.inc)) ? pecs_pkg::CNT_W'(1) : pecs_pkg::CNT_RST));
  endproperty
  a_cnt_rd_clr: assert property (p_cnt_rd_clr) else $error("read clear wrong");

  property p_cnt_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (!c.inc && !c.rd_clr && !c.rst_clr) |=> $stable(cnt_q);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter changed with no cause");

endmodule // pecs_sat_cnt

// File: pecs_regs.sv
// pecs_regs: phy error counters and ten-meg control/status over apb
// assumes: event inputs are one-cycle pulses on core_clk_i; soft_rst_i is a
// one-cycle pulse on core_clk_i; apb master per the apb protocol
`timescale 1ns/1ps

module pecs_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic              core_clk_i,            // core clock, 250 MHz
  input  wire logic              nrst_i,                // async hardware reset, active low
  input  wire logic              soft_rst_i,            // software reset pulse
  input  wire logic              psel_i,                // apb select
  input  wire logic              penable_i,             // apb enable
  input  wire logic              pwrite_i,              // apb write
  input  wire logic [ADDR_W-1:0] paddr_i,               // apb byte address
  input  wire logic [31:0]       pwdata_i,              // apb write data
  input  wire logic [3:0]        pstrb_i,               // apb byte strobes
  output logic      [31:0]       prdata_o,              // apb read data
  output logic                   pready_o,              // apb ready
  output logic                   pslverr_o,             // apb error, unmapped address
  input  wire logic              rx_err_pkt_i,          // errored non-collision packet
  input  wire logic              false_carrier_i,       // false carrier seen
  input  wire logic              carrier_integrity_monitor_unstable_i, // entered unstable
  input  wire logic              eof_err_i,             // end-of-frame error seen
  input  wire logic              ten_disconnect_i,      // ten-meg link disconnect seen
  input  wire logic              ten_link_up_i,         // ten-meg integrity says link up
  input  wire logic              speed_is_ten_i,        // link runs at 10 Mb/s
  output logic                   rx_err_count_valid_o,  // receive count meaningful
  output logic                   link_check_bypass_o,   // bypass integrity machine
  output logic                   ten_link_pass_o,       // ten-meg link pass
  output logic                   jabber_detect_off_o,   // jabber detection off
  output logic                   echo_off_o,            // ten-meg echo off
  output logic                   signal_quality_error_heartbeat_off_o, // heartbeat off
  output pecs_pkg::pecs_squelch_t squelch_sel_o,        // squelch threshold select
  output logic                   irq_o                  // level interrupt
);

  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        take;
  logic        wr_take;
  logic        rd_take;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'(pecs_pkg::byte_addr(idx)));
  endfunction

  // the side effect lands at the edge that captures read data, one edge
  // before completion, so an event between them cannot be lost by a clear
  assign take    = psel_i && penable_i && !pready_q;
  assign wr_take = take && pwrite_i;
  assign rd_take = take && !pwrite_i;

  // ------------------------------------------------------------
  // event counters
  // ------------------------------------------------------------
  pecs_cnt_if rx_if ();
  pecs_cnt_if fc_if ();
  pecs_cnt_if un_if ();

  assign rx_if.inc     = rx_err_pkt_i;
  assign fc_if.inc     = false_carrier_i;
  assign un_if.inc     = carrier_integrity_monitor_unstable_i;
  assign rx_if.rd_clr  = rd_take && hit(paddr_i, pecs_pkg::IDX_RX_ERR_CNT);
  assign fc_if.rd_clr  = rd_take && hit(paddr_i, pecs_pkg::IDX_FALSE_CAR);
  assign un_if.rd_clr  = rd_take && hit(paddr_i, pecs_pkg::IDX_UNSTABLE);
  assign rx_if.rst_clr = soft_rst_i;
  assign fc_if.rst_clr = soft_rst_i;
  assign un_if.rst_clr = soft_rst_i;

  pecs_sat_cnt u_rx_cnt (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .c          (rx_if.ctr)
  );

  pecs_sat_cnt u_fc_cnt (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .c          (fc_if.ctr)
  );

  pecs_sat_cnt u_un_cnt (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .c          (un_if.ctr)
  );

  // ------------------------------------------------------------
  // ten-meg control and status
  // ------------------------------------------------------------
  logic                    force_q, force_d;
  logic                    jab_q, jab_d;
  logic                    echo_q, echo_d;
  logic                    hb_q, hb_d;
  pecs_pkg::pecs_squelch_t sq_q, sq_d;
  logic                    eof_q, eof_d;
  logic                    disc_q, disc_d;
  logic                    link_q, link_d;
  logic                    valid_q, valid_d;
  logic                    cs_wr;
  logic                    cs_rd;

  assign cs_wr = wr_take && hit(paddr_i, pecs_pkg::IDX_TEN_CS) && pstrb_i[1];
  assign cs_rd = rd_take && hit(paddr_i, pecs_pkg::IDX_TEN_CS);

  always_comb begin
    force_d = force_q;
    jab_d   = jab_q;
    echo_d  = echo_q;
    hb_d    = hb_q;
    sq_d    = sq_q;
    if (cs_wr) begin
      force_d = pwdata_i[pecs_pkg::CS_FORCE_LINK];
      jab_d   = pwdata_i[pecs_pkg::CS_JABBER_OFF];
      echo_d  = pwdata_i[pecs_pkg::CS_ECHO_OFF];
      hb_d    = pwdata_i[pecs_pkg::CS_HB_OFF];
      sq_d    = pecs_pkg::pecs_squelch_t'(pwdata_i[pecs_pkg::CS_SQ_HI:pecs_pkg::CS_SQ_LO]);
    end
    // heartbeat control is not sticky; the rest keep their value here
    if (soft_rst_i) begin
      hb_d = pecs_pkg::CS_HB_OFF_RST;
    end
    // self-clearing flags: a new event wins over the read clear
    eof_d  = eof_err_i || (eof_q && !cs_rd);
    disc_d = ten_disconnect_i || (disc_q && !cs_rd);
    if (soft_rst_i) begin
      eof_d  = 1'b0;
      disc_d = 1'b0;
    end
    link_d  = force_q || ten_link_up_i;
    valid_d = !speed_is_ten_i;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      force_q <= pecs_pkg::CS_FORCE_LINK_RST;
      jab_q   <= pecs_pkg::CS_JABBER_OFF_RST;
      echo_q  <= pecs_pkg::CS_ECHO_OFF_RST;
      hb_q    <= pecs_pkg::CS_HB_OFF_RST;
      sq_q    <= pecs_pkg::SQ_NORMAL;
      eof_q   <= 1'b0;
      disc_q  <= 1'b0;
      link_q  <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      force_q <= force_d;
      jab_q   <= jab_d;
      echo_q  <= echo_d;
      hb_q    <= hb_d;
      sq_q    <= sq_d;
      eof_q   <= eof_d;
      disc_q  <= disc_d;
      link_q  <= link_d;
      valid_q <= valid_d;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic [pecs_pkg::IRQ_W-1:0] stat_q, stat_d;
  logic [pecs_pkg::IRQ_W-1:0] en_q, en_d;
  logic [pecs_pkg::IRQ_W-1:0] ev;
  logic [pecs_pkg::IRQ_W-1:0] clr_mask;
  logic                       irq_q, irq_d;

  always_comb begin
    ev                         = '0;
    ev[pecs_pkg::IRQ_RX_ERR]   = rx_err_pkt_i;
    ev[pecs_pkg::IRQ_FALSE]    = false_carrier_i;
    ev[pecs_pkg::IRQ_UNSTAB]   = carrier_integrity_monitor_unstable_i;
    ev[pecs_pkg::IRQ_EOF]      = eof_err_i;
    ev[pecs_pkg::IRQ_DISC]     = ten_disconnect_i;
    clr_mask = '0;
    if (wr_take && hit(paddr_i, pecs_pkg::IDX_IRQ_CLEAR) && pstrb_i[0]) begin
      clr_mask = pwdata_i[pecs_pkg::IRQ_W-1:0];
    end
    en_d = en_q;
    if (wr_take && hit(paddr_i, pecs_pkg::IDX_IRQ_ENABLE) && pstrb_i[0]) begin
      en_d = pwdata_i[pecs_pkg::IRQ_W-1:0];
    end
    // set wins over clear
    stat_d = (stat_q & ~clr_mask) | ev;
    if (soft_rst_i) begin
      stat_d = pecs_pkg::IRQ_RST;
    end
    irq_d = |(stat_d & en_d);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= pecs_pkg::IRQ_RST;
      en_q   <= pecs_pkg::IRQ_RST;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      en_q   <= en_d;
      irq_q  <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // apb read data and ready
  // ------------------------------------------------------------
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = take;
    if (take) begin
      prdata_d = 32'h0000_0000;
      if (hit(paddr_i, pecs_pkg::IDX_RX_ERR_CNT)) begin
        prdata_d[pecs_pkg::CNT_W-1:0] = rx_if.cnt;
      end else if (hit(paddr_i, pecs_pkg::IDX_FALSE_CAR)) begin
        prdata_d[pecs_pkg::CNT_W-1:0] = fc_if.cnt;
      end else if (hit(paddr_i, pecs_pkg::IDX_UNSTABLE)) begin
        prdata_d[pecs_pkg::CNT_W-1:0] = un_if.cnt;
      end else if (hit(paddr_i, pecs_pkg::IDX_TEN_CS)) begin
        prdata_d[pecs_pkg::CS_FORCE_LINK] = force_q;
        prdata_d[pecs_pkg::CS_JABBER_OFF] = jab_q;
        prdata_d[pecs_pkg::CS_ECHO_OFF]   = echo_q;
        prdata_d[pecs_pkg::CS_HB_OFF]     = hb_q;
        prdata_d[pecs_pkg::CS_SQ_HI:pecs_pkg::CS_SQ_LO] = sq_q;
        prdata_d[pecs_pkg::CS_EOF_ERR]    = eof_q;
        prdata_d[pecs_pkg::CS_DISCONNECT] = disc_q;
        prdata_d[pecs_pkg::CS_LINK]       = link_q;
      end else if (hit(paddr_i, pecs_pkg::IDX_IRQ_STATUS)) begin
        prdata_d[pecs_pkg::IRQ_W-1:0] = stat_q;
      end else if (hit(paddr_i, pecs_pkg::IDX_IRQ_ENABLE)) begin
        prdata_d[pecs_pkg::IRQ_W-1:0] = en_q;
      end else if (!hit(paddr_i, pecs_pkg::IDX_IRQ_CLEAR)) begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata_o                             = prdata_q;
  assign pready_o                             = pready_q;
  assign pslverr_o                            = pslverr_q;
  assign rx_err_count_valid_o                 = valid_q;
  assign link_check_bypass_o                  = force_q;
  assign ten_link_pass_o                      = link_q;
  assign jabber_detect_off_o                  = jab_q;
  assign echo_off_o                           = echo_q;
  assign signal_quality_error_heartbeat_off_o = hb_q;
  assign squelch_sel_o                        = sq_q;
  assign irq_o                                = irq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_force_pass;
    @(posedge core_clk_i) disable iff (!nrst_i)
    force_q |=> ten_link_pass_o;
  endproperty
  a_force_pass: assert property (p_force_pass) else $error("forced link not reported as pass");

  property p_link_live;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (!force_q) |=> (ten_link_pass_o == $past(ten_link_up_i));
  endproperty
  a_link_live: assert property (p_link_live) else $error("link status not tracking input");

  property p_sticky_soft;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (soft_rst_i && !cs_wr) |=> ($stable(force_q) && $stable(jab_q) && $stable(echo_q) && $stable(sq_q) && hb_q);
  endproperty
  a_sticky_soft: assert property (p_sticky_soft) else $error("soft reset disturbed controls");

  property p_eof_set;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (eof_err_i && !soft_rst_i) |=> eof_q ##1 (eof_q || $past(cs_rd) || $past(soft_rst_i));
  endproperty
  a_eof_set: assert property (p_eof_set) else $error("eof flag not set");

  property p_disc_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (cs_rd && !ten_disconnect_i) |=> !disc_q;
  endproperty
  a_disc_clr: assert property (p_disc_clr) else $error("disconnect flag not cleared by read");

  property p_reserved_zero;
    @(posedge core_clk_i) disable iff (!nrst_i)
    pready_o |-> (prdata_o[31:16] == 16'h0000 && prdata_o[9] == 1'b0 && prdata_o[5:0] == 6'h00 || !$past(cs_rd));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_ready_one;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready not a single cycle answer");

  property p_irq_level;
    @(posedge core_clk_i) disable iff (!nrst_i)
    irq_o == |(stat_q & en_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt does not match status and enable");

  property p_valid_speed;
    @(posedge core_clk_i) disable iff (!nrst_i)
    speed_is_ten_i |=> !rx_err_count_valid_o;
  endproperty
  a_valid_speed: assert property (p_valid_speed) else $error("count marked valid at 10 Mb/s");

endmodule // pecs_regs

// File: pecs_mgmt_model.sv
// pecs_mgmt_model: management-side apb master that reads and writes the registers
// assumes: the slave answers with pready on core_clk_i; one transfer at a time
`timescale 1ns/1ps
module pecs_mgmt_model (
  input  wire logic        core_clk_i, // core clock
  input  wire logic [31:0] prdata_i,   // read data
  input  wire logic        pready_i,   // ready
  input  wire logic        pslverr_i,  // error
  output logic             psel_o,     // select
  output logic             penable_o,  // enable
  output logic             pwrite_o,   // direction
  output logic [11:0]      paddr_o,    // byte address
  output logic [31:0]      pwdata_o,   // write data
  output logic [3:0]       pstrb_o     // byte strobes
);
  initial begin
    psel_o = 1'h0;
    penable_o = 1'h0;
    pwrite_o = 1'h0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    pstrb_o = 4'h0;
  end

  // ----------------------------------------
  // one transfer; to flags a missing answer
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                      output logic [31:0] rd, output logic err, output logic to);
    int n;
    @(posedge core_clk_i);
    psel_o <= 1'h1;
    penable_o <= 1'h0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= wd;
    pstrb_o <= st;
    @(posedge core_clk_i);
    penable_o <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_i !== 1'h1 && n < 64);
    rd = prdata_i;
    err = pslverr_i;
    to = (pready_i !== 1'h1);
    psel_o <= 1'h0;
    penable_o <= 1'h0;
  endtask
endmodule // pecs_mgmt_model

// File: phy_error_counters_ext_status_test.sv
// phy_error_counters_ext_status_test: register-level checks of pecs_regs
// assumes: pecs_mgmt_model speaks apb; event pulses come from this bench
`timescale 1ns/1ps
module phy_error_counters_ext_status_test;
  logic                    clk, nrst, srst, up, ten, e, t;
  logic                    psel, pen, pwr, rdy, serr, irq, vld, byp, pass, jab, echo, hb;
  logic [4:0]              ev;
  logic [11:0]             pa;
  logic [31:0]             pwd, prd, d;
  logic [3:0]              pst;
  pecs_pkg::pecs_squelch_t sq;
  int                      fails, n_tests;
  logic [11:0]             cnt_a [3] = '{12'h04c, 12'h050, 12'h054};

  pecs_regs #(.ADDR_W(12)) uut (.core_clk_i(clk), .nrst_i(nrst), .soft_rst_i(srst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(serr), .rx_err_pkt_i(ev[0]), .false_carrier_i(ev[1]),
    .carrier_integrity_monitor_unstable_i(ev[2]), .eof_err_i(ev[3]), .ten_disconnect_i(ev[4]),
    .ten_link_up_i(up), .speed_is_ten_i(ten), .rx_err_count_valid_o(vld), .link_check_bypass_o(byp),
    .ten_link_pass_o(pass), .jabber_detect_off_o(jab), .echo_off_o(echo),
    .signal_quality_error_heartbeat_off_o(hb), .squelch_sel_o(sq), .irq_o(irq));

  pecs_mgmt_model m (.core_clk_i(clk), .prdata_i(prd), .pready_i(rdy), .pslverr_i(serr), .psel_o(psel),
    .penable_o(pen), .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd), .pstrb_o(pst));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    m.xfer(1'h1, a, v, 4'hf, d, e, t);
    if (t) begin
      fails++;
      results();
    end
  endtask

  // a read clears counters and flags, so each read is its own check
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    m.xfer(1'h0, a, 32'h0, 4'h0, d, e, t);
    if (t) begin
      fails++;
      results();
    end
    chk(d, exp);
  endtask

  task automatic pulse(input logic [4:0] msk, input int n);
    repeat (n) begin
      @(posedge clk);
      ev <= msk;
      @(posedge clk);
      ev <= 5'h00;
    end
  endtask

  task automatic spulse;
    @(posedge clk);
    srst <= 1'h1;
    @(posedge clk);
    srst <= 1'h0;
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    nrst = 1'h0;
    srst = 1'h0;
    up = 1'h0;
    ten = 1'h0;
    ev = 5'h00;
    fails = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    rdchk(12'h058, 32'h3000);
    chk({25'h0, byp, pass, jab, echo, hb, sq}, 32'h0c);
    for (int i = 0; i < 3; i++) begin
      rdchk(cnt_a[i], 32'h0);
      pulse(5'h01 << i, 3);
      rdchk(cnt_a[i], 32'h3);
      rdchk(cnt_a[i], 32'h0);
      pulse(5'h01 << i, 258);
      rdchk(cnt_a[i], 32'hff);
    end
    wr(12'h04c, 32'hff);
    rdchk(12'h04c, 32'h0);
    pulse(5'h02, 1);
    spulse();
    rdchk(12'h050, 32'h0);
    @(posedge clk);
    ten <= 1'h1;
    repeat (2) @(negedge clk);
    chk({31'h0, vld}, 32'h0);
    @(posedge clk);
    ten <= 1'h0;
    repeat (2) @(negedge clk);
    chk({31'h0, vld}, 32'h1);
    wr(12'h058, 32'hffffffff);
    rdchk(12'h058, 32'hfc40);
    chk({25'h0, byp, pass, jab, echo, hb, sq}, 32'h7f);
    for (int i = 3; i >= 0; i--) begin
      wr(12'h058, 32'hc000 | (i << 10));
      chk({30'h0, sq}, i);
    end
    rdchk(12'h058, 32'hc040);
    spulse();
    rdchk(12'h058, 32'hd040);
    wr(12'h058, 32'h0);
    @(posedge clk);
    up <= 1'h1;
    rdchk(12'h058, 32'h0040);
    chk({30'h0, byp, pass}, 32'h1);
    @(posedge clk);
    up <= 1'h0;
    pulse(5'h18, 1);
    rdchk(12'h058, 32'h0180);
    rdchk(12'h058, 32'h0);
    // interrupt: raise, clear, then mask
    wr(12'h084, 32'h1f);
    wr(12'h088, 32'h1f);
    pulse(5'h04, 1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rdchk(12'h080, 32'h04);
    wr(12'h084, 32'h04);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(12'h088, 32'h0);
    pulse(5'h04, 1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rdchk(12'h080, 32'h04);
    m.xfer(1'h0, 12'h100, 32'h0, 4'h0, d, e, t);
    chk({30'h0, t, e}, 32'h1);
    chk(d, 32'h0);
    // hardware reset in mid-run must bring sticky controls and counts back
    wr(12'h058, 32'h4400);
    rdchk(12'h058, 32'h4400);
    pulse(5'h01, 1);
    @(posedge clk);
    nrst <= 1'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    rdchk(12'h058, 32'h3000);
    rdchk(12'h04c, 32'h0);
    results();
  end
endmodule // phy_error_counters_ext_status_test
